/* File: common/wcb_pkg.sv */
/*
  Shared types and constants of the write-combining store buffer: memory types,
  store and bus-write carriers, the buffer state record and the register map.
  Assumes one processor clock at 100 MHz and a 64-byte cache line.
*/
package wcb_pkg;

  // Geometry
  localparam int ADDR_W = 40;
  localparam int LINE_BYTES = 64;
  localparam int LINE_BITS = LINE_BYTES * 8;
  localparam int LINE_W = ADDR_W - 6;

  // Timing: idle limit for write_through_type combining
  localparam int CLK_PERIOD_NS = 10;
  localparam int WT_TIMEOUT_NS = 160;
  localparam int WT_TIMEOUT_CYC = (WT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map (byte addresses on the plain register port)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SIGNATURE = 8'h08;
  localparam logic [7:0] REG_EXT_FEATURE = 8'h0C;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam int SIG_FAMILY_LSB = 8;
  localparam int FEAT_RANGE_TYPE_BIT = 12;
  localparam int FEAT_PAGE_ATTR_BIT = 16;

  // Memory type of a store or read
  typedef enum logic [2:0] {
    uncacheable_type = 3'h0,
    combining_memory_type = 3'h1,
    write_through_type = 3'h4,
    write_protected_type = 3'h5,
    writeback_type = 3'h6
  } mem_type_t;

  // Buffer fill mode
  typedef enum logic [1:0] {
    MODE_WC = 2'h0,
    MODE_WT = 2'h1,
    MODE_SINGLE = 2'h2
  } buf_mode_t;

  // Top-level states, one-hot
  typedef enum logic [1:0] {
    ST_COLLECT = 2'b01,
    ST_DRAIN = 2'b10
  } wcb_state_e_t;

  // Store from the load-store pipeline
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0] size;
    logic [63:0] data;
    mem_type_t memType;
    logic nonTemporal;
  } store_req_t;

  // Completion events other than stores, one-cycle pulses
  typedef struct packed {
    logic ioOp;
    logic serialize;
    logic flush;
    logic tlbAdSet;
    logic lockReq;
    logic ucRead;
    logic wcRead;
    logic [ADDR_W-1:0] readAddr;
  } wcb_events_t;

  // Outgoing write command
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LINE_BYTES-1:0] mask;
    logic [LINE_BITS-1:0] data;
    logic fullLine;
  } bus_wr_t;

  // Complete state of the buffer
  typedef struct packed {
    wcb_state_e_t state;
    logic [LINE_BYTES-1:0] valid;
    logic [LINE_BITS-1:0] data;
    logic [LINE_W-1:0] lineAddr;
    buf_mode_t mode;
    logic [5:0] nextOff;
    logic [4:0] wtIdle;
    logic splitHigh;
    logic enable;
    bus_wr_t bus;
    logic busValid;
    logic [31:0] rdData;
  } wcb_state_t;

endpackage

/* File: verilog/write_combining_buffer.sv */
/*
  Write-combining store buffer: merges stores into one 64-byte line buffer,
  closes it on completion events and drains it as write commands.
  Assumes stores, events and the register port all come from logic on sys_clk;
  a store is held stable while storeReady is low.
*/
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Stores of 1, 2, 4 or 8 bytes merge into one aligned 64-byte line buffer.
// R2 - Combining-type stores merge at any byte, any order, until the line is full.
// R3 - Write-through stores combine only inside one quadword, contiguous and ascending.
// R4 - Write-through combining starts anywhere; closes on a gap or on filling byte 7.
// R5 - Uncacheable and protected stores never combine; nontemporal writeback stores act as combining.
// R6 - A non-writeback store to another line closes the buffer; writeback stores without the nontemporal hint are ignored.
// R7 - Port input or output operations close combining.
// R8 - Serializing operations close combining.
// R9 - Flush operations force the open buffer to drain.
// R10 - The buffer is closed before a locked operation may start.
// R11 - Uncacheable reads close; combining-type reads close only on a line match.
// R12 - A store of the other combinable type closes the buffer.
// R13 - The buffer closes as soon as all 64 bytes are valid.
// R14 - Write-through combining closes after 16 idle clocks; combining type has no limit.
// R15 - A write-through store crossing a quadword splits: low part closes, high part reopens.
// R16 - A page-table accessed or dirty flag update closes the buffer.
// R17 - A closed buffer drains as one or more write commands carrying its valid bytes.
// R18 - A fully valid buffer leaves as one 64-byte write, not eight quadword writes.
// R19 - Extended feature word reports range types at bit 12, page attributes at bit 16.
// R20 - The signature holds the family code in bits 11 to 8.
// R21 - After draining, all byte flags clear so the next store opens a fresh line.
module write_combining_buffer import wcb_pkg::*; #(
  parameter logic [3:0] FAMILY_CODE = 4'h1  // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Stores from the pipeline
  input wire logic storeValid,
  input wire store_req_t storeReq,
  output logic storeReady,
  // Completion events
  input wire wcb_events_t events,
  output logic lockReady,
  // System write commands
  output logic busValid,
  output bus_wr_t busWr,
  input wire logic busReady,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);

  wcb_state_t q;
  wcb_state_t d;
  logic accept;

  // Handshake outputs and registered data
  assign storeReady = ce && accept;
  assign lockReady = (q.state == ST_COLLECT) && (q.valid == '0);  // [R10]
  assign busValid = q.busValid;
  assign busWr = q.bus;
  assign regRdata = q.rdData;

  // Next-state logic
  always_comb begin
    logic [7:0] sizeMask;
    logic [63:0] fullMask;
    logic [63:0] qwMask;
    logic [63:0] effMask;
    logic [2:0] qwIdx;
    logic [5:0] startOff;
    logic [6:0] endOff;
    logic [5:0] diff;
    logic [2:0] lane;
    logic isIgnored;
    logic isWc;
    logic isWt;
    logic crossQw;
    logic anyOpen;
    logic closeEvt;
    logic compatible;
    logic closeAfter;
    logic takeStore;
    logic wcMatch;
    logic found;
    logic [2:0] sendQw;
    logic [6:0] popCnt;
    d = q;
    sizeMask = 8'h00;
    fullMask = '0;
    qwMask = '0;
    effMask = '0;
    qwIdx = storeReq.addr[5:3];
    startOff = '0;
    endOff = '0;
    diff = '0;
    lane = '0;
    isIgnored = 1'b0;
    isWc = 1'b0;
    isWt = 1'b0;
    crossQw = 1'b0;
    anyOpen = (q.valid != '0);
    closeEvt = 1'b0;
    compatible = 1'b0;
    closeAfter = 1'b0;
    takeStore = 1'b0;
    wcMatch = 1'b0;
    found = 1'b0;
    sendQw = '0;
    popCnt = '0;
    accept = 1'b0;

    // Store classification and byte masks
    sizeMask = 8'hFF >> (4'd8 - storeReq.size);  // [R1]
    fullMask = 64'(sizeMask) << storeReq.addr[5:0];
    qwMask = 64'h0000_0000_0000_00FF << {qwIdx, 3'b000};
    crossQw = |(fullMask & ~qwMask);
    isWc = (storeReq.memType == combining_memory_type) ||
           (storeReq.memType == writeback_type && storeReq.nonTemporal);  // [R5]
    isWt = (storeReq.memType == write_through_type);
    isIgnored = (storeReq.memType == writeback_type) && !storeReq.nonTemporal;  // [R6]
    if (isWt && q.splitHigh) begin
      effMask = fullMask & ~qwMask;  // [R15]
      startOff = {qwIdx + 3'd1, 3'b000};
      endOff = 7'(storeReq.addr[5:0]) + 7'(storeReq.size);
    end else if (isWt && crossQw) begin
      effMask = fullMask & qwMask;  // [R15]
      startOff = storeReq.addr[5:0];
      endOff = 7'({qwIdx, 3'b000}) + 7'd8;
    end else begin
      effMask = fullMask;
      startOff = storeReq.addr[5:0];
      endOff = 7'(storeReq.addr[5:0]) + 7'(storeReq.size);
    end

    // Completion events that close an open buffer
    wcMatch = events.wcRead && (events.readAddr[ADDR_W-1:6] == q.lineAddr);  // [R11]
    closeEvt = events.ioOp || events.serialize || events.flush || events.tlbAdSet ||
               events.lockReq || events.ucRead || wcMatch;  // [R7] [R8] [R9] [R10] [R11] [R16]

    // Compatibility of an incoming store with the open buffer
    if (isWc) begin
      compatible = (q.mode == MODE_WC) && q.enable &&
                   (storeReq.addr[ADDR_W-1:6] == q.lineAddr);  // [R2] [R6] [R12]
    end else if (isWt) begin
      compatible = (q.mode == MODE_WT) && q.enable &&
                   (storeReq.addr[ADDR_W-1:6] == q.lineAddr) &&
                   (startOff == q.nextOff);  // [R3] [R4] [R12]
    end

    // Register writes
    if (regWr && regAddr == REG_CTRL) begin
      d.enable = regWdata[0];
    end

    unique case (q.state)
      ST_COLLECT: begin
        if (anyOpen && closeEvt) begin
          d.state = ST_DRAIN;
        end else if (storeValid && isIgnored) begin
          accept = 1'b1;
        end else if (storeValid && (!anyOpen || compatible)) begin
          takeStore = 1'b1;
        end else if (storeValid && anyOpen) begin
          d.state = ST_DRAIN;  // [R6] [R12] [R4]
        end else if (anyOpen && q.mode == MODE_WT && 32'(q.wtIdle) >= WT_TIMEOUT_CYC - 1) begin
          d.state = ST_DRAIN;  // [R14]
        end
        if (anyOpen && q.mode == MODE_WT) begin
          d.wtIdle = q.wtIdle + 5'd1;
        end
        // Merge the store bytes into the line
        if (takeStore) begin
          for (int b = 0; b < LINE_BYTES; b++) begin
            diff = 6'(b) - storeReq.addr[5:0];
            lane = diff[2:0];
            if (effMask[b]) begin
              d.data[b*8 +: 8] = storeReq.data[lane*8 +: 8];
              d.valid[b] = 1'b1;
            end
          end
          d.lineAddr = storeReq.addr[ADDR_W-1:6];
          d.nextOff = endOff[5:0];
          d.wtIdle = '0;
          d.mode = isWc ? MODE_WC : (isWt ? MODE_WT : MODE_SINGLE);  // [R5]
          closeAfter = !q.enable || !(isWc || isWt);  // [R5]
          if (isWt && (endOff[2:0] == 3'd0)) begin
            closeAfter = 1'b1;  // [R4]
          end
          if (d.valid == '1) begin
            closeAfter = 1'b1;  // [R13]
          end
          if (isWt && crossQw && !q.splitHigh) begin
            d.splitHigh = 1'b1;  // [R15]
            closeAfter = 1'b1;
          end else begin
            d.splitHigh = 1'b0;
            accept = 1'b1;
          end
          if (closeAfter) begin
            d.state = ST_DRAIN;
          end
        end
        // A completely valid line closes without further stores
        if (q.valid == '1) begin
          d.state = ST_DRAIN;  // [R13]
        end
      end
      ST_DRAIN: begin
        if (q.busValid && busReady) begin
          d.busValid = 1'b0;
        end
        if (!q.busValid || busReady) begin
          if (q.valid == '1) begin
            d.bus.addr = {q.lineAddr, 6'h00};  // [R18]
            d.bus.mask = q.valid;
            d.bus.data = q.data;
            d.bus.fullLine = 1'b1;
            d.busValid = 1'b1;
            d.valid = '0;
          end else if (q.valid != '0) begin
            for (int k = 7; k >= 0; k--) begin
              if (q.valid[k*8 +: 8] != 8'h00) begin
                found = 1'b1;
                sendQw = 3'(k);
              end
            end
            d.bus.addr = {q.lineAddr, sendQw, 3'b000};  // [R17]
            d.bus.mask = q.valid & (64'h0000_0000_0000_00FF << {sendQw, 3'b000});
            d.bus.data = q.data;
            d.bus.fullLine = 1'b0;
            d.busValid = found;
            d.valid = q.valid & ~(64'h0000_0000_0000_00FF << {sendQw, 3'b000});
          end else begin
            d.state = ST_COLLECT;  // [R21]
            d.mode = MODE_WC;
            d.wtIdle = '0;
          end
        end
      end
    endcase

    // Register reads, data one cycle after the strobe
    for (int b = 0; b < LINE_BYTES; b++) begin
      popCnt = popCnt + 7'(q.valid[b]);
    end
    d.rdData = 32'h0000_0000;
    if (regRd) begin
      unique case (regAddr)
        REG_CTRL: d.rdData = {31'h0000_0000, q.enable};
        REG_STATUS: d.rdData = {17'h0_0000, popCnt, 4'h0, q.splitHigh,
                                q.mode == MODE_WT, q.state == ST_DRAIN, anyOpen};
        REG_SIGNATURE: d.rdData = 32'(FAMILY_CODE) << SIG_FAMILY_LSB;  // [R20]
        REG_EXT_FEATURE: d.rdData = (32'h0000_0001 << FEAT_RANGE_TYPE_BIT) |
                                    (32'h0000_0001 << FEAT_PAGE_ATTR_BIT);  // [R19]
        default: d.rdData = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.state <= ST_COLLECT;
      q.mode <= MODE_WC;
      q.enable <= CTRL_ENABLE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // Plain combining-type store on the input
  logic isWcIn;
  assign isWcIn = (storeReq.memType == combining_memory_type);

  // Checks on the buffer behaviour
  sequence s_drain_done;
    q.state == ST_DRAIN ##1 q.state == ST_COLLECT;
  endsequence

  sequence s_wc_foreign;
    q.state == ST_COLLECT && q.valid != '0 && q.mode == MODE_WC && storeValid && isWcIn &&
    storeReq.addr[ADDR_W-1:6] != q.lineAddr && events == '0;
  endsequence

  property p_full_close;
    @(posedge sys_clk) disable iff (rst || !ce)
    (q.state == ST_COLLECT && q.valid == '1) |=> q.state == ST_DRAIN;
  endproperty
  a_full_close: assert property (p_full_close) else $error("full line did not close");  // [R13]

  property p_full_write;
    @(posedge sys_clk) disable iff (rst)
    (busValid && busWr.fullLine) |-> (busWr.mask == '1 && busWr.addr[5:0] == 6'h00);
  endproperty
  a_full_write: assert property (p_full_write) else $error("full write not one whole line");  // [R18]

  property p_qw_write;
    @(posedge sys_clk) disable iff (rst)
    (busValid && !busWr.fullLine) |->
      (busWr.mask != '0 && (busWr.mask & ~(64'h0000_0000_0000_00FF << {busWr.addr[5:3], 3'b000})) == '0);
  endproperty
  a_qw_write: assert property (p_qw_write) else $error("partial write spans quadwords");  // [R17]

  property p_drain_clears;
    @(posedge sys_clk) disable iff (rst || !ce)
    s_drain_done |-> q.valid == '0 && !q.busValid;
  endproperty
  a_drain_clears: assert property (p_drain_clears) else $error("buffer not empty after drain");  // [R21]

  property p_event_close;
    @(posedge sys_clk) disable iff (rst || !ce)
    (q.state == ST_COLLECT && q.valid != '0 &&
     (events.ioOp || events.serialize || events.flush || events.tlbAdSet))
      |-> !storeReady ##1 q.state == ST_DRAIN;
  endproperty
  a_event_close: assert property (p_event_close) else $error("event did not close buffer");  // [R8]

  property p_lock_wait;
    @(posedge sys_clk) disable iff (rst || !ce)
    (q.state == ST_COLLECT && q.valid != '0 && events.lockReq) |-> !lockReady ##1 !lockReady;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock allowed with open buffer");  // [R10]

  property p_foreign_line;
    @(posedge sys_clk) disable iff (rst || !ce)
    s_wc_foreign |-> !storeReady ##1 q.state == ST_DRAIN;
  endproperty
  a_foreign_line: assert property (p_foreign_line) else $error("other line merged");  // [R6]

  property p_wt_timeout;
    @(posedge sys_clk) disable iff (rst || !ce)
    (q.state == ST_COLLECT && q.mode == MODE_WT && q.valid != '0 && !storeValid && events == '0)[*8]
      |-> ##[1:9] q.state == ST_DRAIN;
  endproperty
  a_wt_timeout: assert property (p_wt_timeout) else $error("write-through idle limit missed");  // [R14]

  property p_signature;
    @(posedge sys_clk) disable iff (rst || !ce)
    (regRd && regAddr == REG_SIGNATURE) |=> regRdata[11:8] == FAMILY_CODE;
  endproperty
  a_signature: assert property (p_signature) else $error("family code wrong");  // [R20]

  property p_uc_read;
    @(posedge sys_clk) disable iff (rst || !ce)
    (q.state == ST_COLLECT && q.valid != '0 && events.ucRead) |=> q.state == ST_DRAIN ##1 !storeReady;
  endproperty
  a_uc_read: assert property (p_uc_read) else $error("uncacheable read did not close");  // [R11]

  property p_type_change;
    @(posedge sys_clk) disable iff (rst || !ce)
    (q.state == ST_COLLECT && q.valid != '0 && q.mode == MODE_WT && storeValid && isWcIn && events == '0)
      |-> !storeReady ##1 q.state == ST_DRAIN;
  endproperty
  a_type_change: assert property (p_type_change) else $error("type change did not close");  // [R12]

  property p_wt_byte7;
    @(posedge sys_clk) disable iff (rst || !ce)
    (storeReady && storeReq.memType == write_through_type && (4'(storeReq.addr[2:0]) + storeReq.size) == 4'h8)
      |=> q.state == ST_DRAIN;
  endproperty
  a_wt_byte7: assert property (p_wt_byte7) else $error("byte 7 write did not close");  // [R4]

  // Parameter check at elaboration
  if (FAMILY_CODE == 4'h0) begin : gBadFamily
    $error("family code must be nonzero");
  end

endmodule

/* File: verif/wcb_bus_sink.sv */
/*
  System bus model for the write-combining buffer: takes write commands with
  random stalls and merges what it took into one line image for the bench.
  Assumes one sys_clk domain and a clear pulse from the bench between tests.
*/
`timescale 1ns/1ps
module wcb_bus_sink import wcb_pkg::*; (
  // Clock, reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clr,
  // Write commands
  input wire logic busValid,
  input wire bus_wr_t busWr,
  output logic busReady,
  // Summary of what was taken
  output logic [7:0] nCmd,
  output logic [7:0] nFull,
  output logic [LINE_BYTES-1:0] gotMask,
  output logic [LINE_BITS-1:0] gotData,
  output logic [LINE_W-1:0] gotLine
);
  integer seed = 76;
  initial busReady = 1'b0;
  // Random stall, then merge each taken command into the image
  always @(posedge sys_clk) begin
    busReady <= ($random(seed) & 3) != 0;
    if (rst || clr) begin
      nCmd <= '0;
      nFull <= '0;
      gotMask <= '0;
      gotData <= '0;
      gotLine <= '0;
    end else if (busValid && busReady) begin
      nCmd <= nCmd + 8'h01;
      gotLine <= busWr.addr[ADDR_W-1:6];
      nFull <= nFull + {7'h00, busWr.fullLine};
      gotMask <= gotMask | busWr.mask;
      for (int i = 0; i < LINE_BYTES; i++) begin
        if (busWr.mask[i]) gotData[i*8 +: 8] <= busWr.data[i*8 +: 8];
      end
    end
  end
endmodule

/* File: verif/write_combining_buffer_tb_top.sv */
/*
  Self-checking bench of the write-combining buffer: random and corner stores,
  every completion event, register reads and writes, drains checked by image.
  Assumes wcb_bus_sink stands on the system side; clock enable drops once for a freeze check.
*/
`timescale 1ns/1ps
module write_combining_buffer_tb_top import wcb_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic storeValid = 1'b0;
  store_req_t storeReq = '0;
  logic storeReady, lockReady, busValid, busReady;
  wcb_events_t events = '0;
  bus_wr_t busWr;
  logic [7:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata, rd;
  logic [7:0] nCmd, nFull;
  logic [LINE_BYTES-1:0] gotMask, expMask;
  logic [LINE_BITS-1:0] gotData, expLine;
  logic [LINE_W-1:0] gotLine, expLineNo;
  integer seed = 76;
  integer err_count = 0;
  integer cmp_count = 0;
  localparam logic [3:0] FAM = 4'h9;  // Arbitrary value
  // Type and address pairs for the closing scenarios
  mem_type_t t1 [3] = '{combining_memory_type, write_through_type, combining_memory_type};
  mem_type_t t2 [3] = '{combining_memory_type, combining_memory_type, write_through_type};
  logic [ADDR_W-1:0] a2 [3] = '{40'h00_01C0, 40'h00_0101, 40'h00_0108};

  always #5 sys_clk = ~sys_clk;

  write_combining_buffer #(.FAMILY_CODE(FAM)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .storeValid(storeValid), .storeReq(storeReq), .storeReady(storeReady), .events(events),
    .lockReady(lockReady), .busValid(busValid), .busWr(busWr), .busReady(busReady),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  wcb_bus_sink sink (.sys_clk(sys_clk), .rst(rst), .clr(clr), .busValid(busValid), .busWr(busWr),
    .busReady(busReady), .nCmd(nCmd), .nFull(nFull), .gotMask(gotMask), .gotData(gotData), .gotLine(gotLine));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [LINE_BITS-1:0] seen, input logic [LINE_BITS-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Quadwords holding at least one valid byte
  function automatic int qw_count(input logic [LINE_BYTES-1:0] m);
    int n = 0;
    for (int q = 0; q < 8; q++) n += (m[q*8 +: 8] != 8'h00);
    return n;
  endfunction

  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    rd = regRdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // One store, held until taken; rec adds its bytes to the expected image
  task automatic store(input logic [ADDR_W-1:0] a, input logic [3:0] sz, input mem_type_t mt,
                       input logic nt, input logic rec);
    logic [63:0] d;
    int i;
    d = {$random(seed), $random(seed)};
    @(posedge sys_clk);
    storeValid <= 1'b1;
    storeReq <= '{addr: a, size: sz, data: d, memType: mt, nonTemporal: nt};
    for (i = 0; i < 300; i++) begin
      @(negedge sys_clk);
      if (storeReady === 1'b1) break;
    end
    if (i == 300) begin
      err_count++;
      report_and_stop();
    end
    @(posedge sys_clk);
    storeValid <= 1'b0;
    if (rec) expLineNo = a[ADDR_W-1:6];
    for (int b = 0; b < 8; b++) begin
      if (rec && b < sz && a[5:0] + b < 64) begin
        expMask[a[5:0] + b] = 1'b1;
        expLine[(a[5:0] + b) * 8 +: 8] = d[b*8 +: 8];
      end
    end
  endtask

  // Pulse one event: 0 io, 1 serialize, 2 flush, 3 table flag, 4 lock, 5 uc read, 6 wc read
  task automatic pulse(input int k, input logic [ADDR_W-1:0] ra);
    @(posedge sys_clk);
    events <= {7'h40 >> k, ra};
    @(posedge sys_clk);
    events <= '0;
  endtask

  task automatic clear_sink();
    expMask = '0;
    expLine = '0;
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask

  // Wait for the expected commands, then compare count, kind, mask and data
  task automatic expect_drain(input int bound);
    int n;
    int i;
    n = (&expMask) ? 1 : qw_count(expMask);
    for (i = 0; i < bound && nCmd !== n[7:0]; i++) @(negedge sys_clk);
    if (nCmd !== n[7:0]) begin
      err_count++;
      report_and_stop();
    end
    repeat (4) @(negedge sys_clk);
    check(nCmd, n);
    check(nFull, (&expMask) ? 1 : 0);
    check(gotMask, expMask);
    check(gotData, expLine);
    check(gotLine, expLineNo);
    clear_sink();
  endtask

  // Drop leftovers of a scenario
  task automatic settle();
    pulse(2, '0);
    repeat (60) @(posedge sys_clk);
    clear_sink();
  endtask

  initial begin
    int r;
    expMask = '0;
    expLine = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Registers
    rd_reg(REG_SIGNATURE);
    check(rd[11:8], FAM);
    rd_reg(REG_EXT_FEATURE);
    check({rd[16], rd[12]}, 2'b11);
    rd_reg(REG_CTRL);
    check(rd[0], CTRL_ENABLE_RST);
    rd_reg(8'h10);
    check(rd, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_0000);
    rd_reg(REG_CTRL);
    check(rd[0], 1'b0);
    store(40'h00_0A00, 4'h2, combining_memory_type, 0, 1);
    expect_drain(12);
    wr_reg(REG_CTRL, 32'h0000_0001);
    $display("test registers done");
    // Full line, quadwords in scrambled order
    r = $random(seed) & 7;
    for (int i = 0; i < 8; i++) store(40'h00_0100 + ((i * 5 + r) & 7) * 8, 4'h8, combining_memory_type, 0, 1);
    expect_drain(40);
    $display("test full line done");
    // Scattered small stores, then flush
    for (int i = 0; i < 6; i++) store(40'h00_0200 + ($random(seed) & 60), 4'h1 << ($random(seed) & 1),
                                      combining_memory_type, 0, 1);
    rd_reg(REG_STATUS);
    check(rd[0], 1'b1);
    pulse(2, '0);
    expect_drain(60);
    rd_reg(REG_STATUS);
    check(rd[14:8], 7'h00);
    $display("test flush done");
    // Every closing event except flush with an open buffer
    for (int k = 0; k < 7; k++) begin
      if (k == 2) continue;
      store(40'h00_0340 + k * 8, 4'h4, combining_memory_type, 0, 1);
      pulse(k, 40'h00_0348);
      expect_drain(40);
      check(lockReady, 1'b1);
    end
    // Combining read of another line, no timeout on combining type
    store(40'h00_0380, 4'h2, combining_memory_type, 0, 1);
    pulse(6, 40'h00_0900);
    repeat (40) @(negedge sys_clk);
    check(nCmd, 8'h00);
    pulse(2, '0);
    expect_drain(40);
    $display("test events done");
    // Write-through contiguous run closed by idle time
    store(40'h00_0203, 4'h1, write_through_type, 0, 1);
    store(40'h00_0204, 4'h2, write_through_type, 0, 1);
    repeat (10) @(negedge sys_clk);
    check(nCmd, 8'h00);
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (30) @(negedge sys_clk);
    check(nCmd, 8'h00);
    @(posedge sys_clk);
    ce <= 1'b1;
    expect_drain(40);
    // Write-through fill of byte 7 closes at once
    store(40'h00_0306, 4'h2, write_through_type, 0, 1);
    expect_drain(12);
    // Crossing write-through store: low part, then high part
    store(40'h00_0706, 4'h4, write_through_type, 0, 1);
    expect_drain(80);
    // Non-contiguous write-through store closes
    store(40'h00_0222, 4'h1, write_through_type, 0, 1);
    store(40'h00_0220, 4'h1, write_through_type, 0, 0);
    expect_drain(40);
    settle();
    $display("test write-through done");
    // Other line and other type close the open buffer
    for (int j = 0; j < 3; j++) begin
      store(40'h00_0100 + (j << 10), 4'h1, t1[j], 0, 1);
      store(a2[j] + (j << 10), 4'h1, t2[j], 0, 0);
      expect_drain(40);
      settle();
    end
    // Uncacheable store goes alone; nontemporal writeback combines; plain writeback dropped
    store(40'h00_0600, 4'h4, uncacheable_type, 0, 1);
    expect_drain(12);
    store(40'h00_0610, 4'h1, writeback_type, 1, 1);
    store(40'h00_0611, 4'h1, writeback_type, 1, 1);
    store(40'h00_0630, 4'h8, writeback_type, 0, 0);
    pulse(2, '0);
    expect_drain(40);
    $display("test memory types done");
    report_and_stop();
  end
endmodule
